/* File: hw/uilc_pkg.sv */
// uilc_pkg: constants and types of the uart / infrared / lin controller
package uilc_pkg;
	localparam int DEPTH = 8;
	localparam int PW = 3;
	localparam int CW = 4;
	localparam int BLW = 22;
	localparam int IR_SH = 4;
	localparam logic [CW-1:0] FIFO_FULL = 4'h8;
	localparam logic [16:0] DIV_ADD = 17'h00002;
	localparam logic [4:0] OVS_M0 = 5'h10;
	localparam logic [4:0] ONE5 = 5'h01;
	localparam logic [1:0] IR_NUM = 2'h3;
	localparam logic [4:0] BRK_ADD = 5'h02;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [5:0] TOUT_BITS = 6'h28;
	localparam int RX_BRK = 2;
	localparam int RX_FRM = 1;
	localparam int RX_PAR = 0;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000, T_BRK = 3'b001, T_START = 3'b010,
		T_DATA = 3'b011, T_PAR = 3'b100, T_STOP = 3'b101
	} uilc_tx_st_t;
	typedef enum logic [2:0] {
		R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b010,
		R_PAR = 3'b011, R_STOP = 3'b100, R_BRKW = 3'b101
	} uilc_rx_st_t;
endpackage : uilc_pkg

/* File: hw/uilc_top.sv */
// uilc_top: uart with fifos, integer baud divider, flow control, infrared and lin master
`timescale 1ns/10ps
`default_nettype none
module uilc_top import uilc_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic [2:0] rx_err,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic baud_mode_hi,
	input wire logic baud_mode_lo,
	input wire logic [15:0] baud_divider,
	input wire logic [3:0] extra_divider,
	input wire logic parity_enable,
	input wire logic parity_even,
	input wire logic auto_rts_en,
	input wire logic auto_cts_en,
	input wire logic [3:0] flow_trigger_level,
	input wire logic [3:0] rx_trigger_level,
	input wire logic infrared_enable,
	input wire logic rx_invert,
	input wire logic lin_mode_enable,
	input wire logic [3:0] break_length,
	input wire logic lin_tx_start,
	input wire logic ser_rx,
	output logic ser_tx,
	input wire logic cts_n,
	output logic rts_n,
	input wire logic ir_rx,
	output logic ir_tx,
	output logic [3:0] tx_count,
	output logic [3:0] rx_count,
	output logic tx_busy,
	output logic rx_busy,
	output logic lin_tx_active,
	output logic tx_empty_irq,
	output logic rx_threshold_irq,
	output logic line_error_irq,
	output logic rx_timeout_irq,
	output logic modem_change_irq,
	output logic buffer_error_irq,
	output logic lin_break_irq
);
	// ----------------------------------------
	// baud generator
	// ----------------------------------------
	logic [16:0] dv;
	logic [4:0] mul;
	logic [BLW-1:0] bit_len, half_len, str_len, ir_pw;
	logic [BLW+1:0] ir_prod;
	assign dv = {1'b0, baud_divider} + DIV_ADD;
	always_comb begin
		case ({baud_mode_hi, baud_mode_lo})
			2'b10: mul = {1'b0, extra_divider} + ONE5;
			2'b11: mul = ONE5;
			default: mul = OVS_M0;
		endcase
	end
	assign bit_len = dv * mul;
	assign half_len = bit_len >> 1;
	assign str_len = bit_len - (bit_len >> 2);
	// pulse width scales with the bit, so any rate up to sir maximum works
	assign ir_prod = bit_len * IR_NUM;
	assign ir_pw = {2'b00, ir_prod[BLW+1:IR_SH]};

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] rx_s, cts_s, ir_s;
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_s <= 2'b11;
			// keeps tracking the pin so no false modem change follows reset
			cts_s <= {cts_s[0], cts_n};
			ir_s <= 2'b11;
		end else begin
			rx_s <= {rx_s[0], ser_rx};
			cts_s <= {cts_s[0], cts_n};
			ir_s <= {ir_s[0], ir_rx};
		end
	end

	// ----------------------------------------
	// infrared decoder
	// ----------------------------------------
	uilc_tx_st_t tx_st;
	uilc_rx_st_t rx_st;
	logic ir_lvl, ir_prev_r, ir_fall, ir_nrz, rx_line;
	logic [BLW-1:0] str_cnt_r;
	assign ir_lvl = ir_s[1] ^ rx_invert;
	assign ir_fall = ir_prev_r & ~ir_lvl;
	// short pulse stretched past mid-bit so the sampler sees it
	always_ff @(posedge clk) begin
		if (reset) begin
			ir_prev_r <= 1'b1;
			str_cnt_r <= '0;
		end else begin
			ir_prev_r <= ir_lvl;
			if (ir_fall)
				str_cnt_r <= str_len;
			else if (str_cnt_r != '0)
				str_cnt_r <= str_cnt_r - 1'b1;
		end
	end
	assign ir_nrz = ~(ir_fall | (str_cnt_r != '0));
	// own transmission masks the receiver in infrared mode
	assign rx_line = infrared_enable ? ((tx_st != T_IDLE) | ir_nrz) : rx_s[1];

	// ----------------------------------------
	// transmit fifo
	// ----------------------------------------
	logic [7:0] tmem [DEPTH];
	logic [PW-1:0] twp_r, trp_r;
	logic [CW-1:0] tfc_r;
	logic tx_push, tx_pop;
	assign tx_push = tx_valid & tx_ready;
	always_ff @(posedge clk) begin
		if (tx_push)
			tmem[twp_r] <= tx_data;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			twp_r <= '0;
			trp_r <= '0;
			tfc_r <= '0;
			tx_ready <= 1'b0;
		end else begin
			twp_r <= twp_r + PW'(tx_push);
			trp_r <= trp_r + PW'(tx_pop);
			tfc_r <= tfc_r + CW'(tx_push) - CW'(tx_pop);
			tx_ready <= (tfc_r + CW'(tx_push) - CW'(tx_pop)) != FIFO_FULL;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	logic [BLW-1:0] tt_r;
	logic [2:0] ti_r;
	logic [4:0] tbc_r;
	logic [7:0] tsh_r;
	logic tpar_r, tx_bit_r, lin_go_r, cts_ok, ir_block, bit_end, par_on;
	assign cts_ok = ~auto_cts_en | ~cts_s[1];
	assign ir_block = infrared_enable & ((rx_st != R_IDLE) | ~rx_line);
	assign bit_end = tt_r == bit_len - 1'b1;
	assign par_on = parity_enable & ~infrared_enable & ~lin_mode_enable;
	assign tx_pop = (tx_st == T_IDLE) & ~lin_go_r & (tfc_r != '0) & cts_ok & ~ir_block;
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_st <= T_IDLE;
			tt_r <= '0;
			ti_r <= '0;
			tbc_r <= '0;
			tsh_r <= '0;
			tpar_r <= 1'b0;
			tx_bit_r <= 1'b1;
		end else begin
			tt_r <= (tx_st == T_IDLE || bit_end) ? '0 : tt_r + 1'b1;
			case (tx_st)
				T_IDLE: begin
					if (lin_go_r && !ir_block) begin
						tx_st <= T_BRK;
						tbc_r <= {1'b0, break_length} + BRK_ADD - ONE5;
						tx_bit_r <= 1'b0;
					end else if (tx_pop) begin
						tx_st <= T_START;
						tsh_r <= tmem[trp_r];
						tpar_r <= parity_even ? ^tmem[trp_r] : ~^tmem[trp_r];
						tx_bit_r <= 1'b0;
					end
				end
				T_BRK: if (bit_end) begin
					tbc_r <= tbc_r - ONE5;
					if (tbc_r == '0) begin
						tx_st <= T_STOP;
						tx_bit_r <= 1'b1;
					end
				end
				T_START: if (bit_end) begin
					tx_st <= T_DATA;
					ti_r <= '0;
					tx_bit_r <= tsh_r[0];
				end
				T_DATA: if (bit_end) begin
					tsh_r <= tsh_r >> 1;
					ti_r <= ti_r + 1'b1;
					if (ti_r == LAST_BIT) begin
						tx_st <= par_on ? T_PAR : T_STOP;
						tx_bit_r <= par_on ? tpar_r : 1'b1;
					end else begin
						tx_bit_r <= tsh_r[1];
					end
				end
				T_PAR: if (bit_end) begin
					tx_st <= T_STOP;
					tx_bit_r <= 1'b1;
				end
				T_STOP: if (bit_end)
					tx_st <= T_IDLE;
				default: tx_st <= T_IDLE;
			endcase
		end
	end
	// set by start request wins over the self clear
	always_ff @(posedge clk) begin
		if (reset)
			lin_go_r <= 1'b0;
		else if (lin_tx_start && lin_mode_enable)
			lin_go_r <= 1'b1;
		else if (tx_st == T_BRK && bit_end && tbc_r == '0)
			lin_go_r <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			ser_tx <= 1'b1;
			ir_tx <= 1'b0;
		end else begin
			ser_tx <= infrared_enable | tx_bit_r;
			ir_tx <= infrared_enable & (tx_st != T_IDLE) & ~tx_bit_r & (tt_r < ir_pw);
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	logic [BLW-1:0] rt_r;
	logic [2:0] ri_r;
	logic [7:0] rsh_r;
	logic rpe_r, rx_done, rx_full, rx_gate, stop_bad, brk_now;
	logic [10:0] rx_word;
	assign rx_gate = ~(auto_rts_en & rts_n);
	assign rx_done = (rx_st == R_STOP) && (rt_r == '0);
	assign rx_full = rx_count == FIFO_FULL;
	assign stop_bad = ~rx_line;
	assign brk_now = stop_bad & (rsh_r == '0);
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_st <= R_IDLE;
			rt_r <= '0;
			ri_r <= '0;
			rsh_r <= '0;
			rpe_r <= 1'b0;
		end else begin
			rt_r <= (rt_r == '0) ? bit_len - 1'b1 : rt_r - 1'b1;
			case (rx_st)
				R_IDLE: if (!rx_line && rx_gate) begin
					rx_st <= R_START;
					rt_r <= half_len;
				end
				R_START: if (rt_r == '0) begin
					rx_st <= rx_line ? R_IDLE : R_DATA;
					ri_r <= '0;
					rpe_r <= 1'b0;
				end
				R_DATA: if (rt_r == '0) begin
					rsh_r <= {rx_line, rsh_r[7:1]};
					ri_r <= ri_r + 1'b1;
					if (ri_r == LAST_BIT)
						rx_st <= par_on ? R_PAR : R_STOP;
				end
				R_PAR: if (rt_r == '0) begin
					rpe_r <= rx_line != (parity_even ? ^rsh_r : ~^rsh_r);
					rx_st <= R_STOP;
				end
				R_STOP: if (rt_r == '0)
					rx_st <= stop_bad ? R_BRKW : R_IDLE;
				R_BRKW: if (rx_line)
					rx_st <= R_IDLE;
				default: rx_st <= R_IDLE;
			endcase
		end
	end
	assign rx_word = {brk_now, stop_bad, rpe_r, rsh_r};

	// ----------------------------------------
	// receive fifo and two-entry output buffer
	// ----------------------------------------
	logic [10:0] rmem [DEPTH];
	logic [10:0] ob_q [2];
	logic [PW-1:0] rwp_r, rrp_r;
	logic [1:0] ob_cnt_r, ob_nxt, ob_pos;
	logic rx_push, rx_pop, ob_pop;
	assign rx_push = rx_done & ~rx_full;
	assign ob_pop = rx_valid & rx_ready;
	assign rx_pop = (rx_count != '0) & ((ob_cnt_r != 2'h2) | ob_pop);
	assign ob_pos = ob_cnt_r - {1'b0, ob_pop};
	assign ob_nxt = ob_pos + {1'b0, rx_pop};
	always_ff @(posedge clk) begin
		if (rx_push)
			rmem[rwp_r] <= rx_word;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			rwp_r <= '0;
			rrp_r <= '0;
			rx_count <= '0;
			ob_cnt_r <= '0;
			rx_valid <= 1'b0;
		end else begin
			rwp_r <= rwp_r + PW'(rx_push);
			rrp_r <= rrp_r + PW'(rx_pop);
			rx_count <= rx_count + CW'(rx_push) - CW'(rx_pop);
			ob_cnt_r <= ob_nxt;
			rx_valid <= ob_nxt != '0;
		end
	end
	always_ff @(posedge clk) begin
		if (ob_pop)
			ob_q[0] <= ob_q[1];
		if (rx_pop) begin
			if (ob_pos == '0)
				ob_q[0] <= rmem[rrp_r];
			else
				ob_q[1] <= rmem[rrp_r];
		end
	end
	assign rx_data = ob_q[0][7:0];
	assign rx_err = ob_q[0][10:8];

	// ----------------------------------------
	// flow control, timeout, status and interrupts
	// ----------------------------------------
	logic [BLW-1:0] tck_r;
	logic [5:0] tbits_r;
	logic cts_prev_r;
	always_ff @(posedge clk) begin
		if (reset)
			rts_n <= 1'b0;
		else
			rts_n <= auto_rts_en & (rx_count >= flow_trigger_level);
	end
	// idle time counted in bit times, restarted by any receive activity
	always_ff @(posedge clk) begin
		if (reset || rx_st != R_IDLE || rx_pop || rx_count == '0) begin
			tck_r <= '0;
			tbits_r <= '0;
		end else if (tbits_r != TOUT_BITS) begin
			tck_r <= (tck_r == bit_len - 1'b1) ? '0 : tck_r + 1'b1;
			if (tck_r == bit_len - 1'b1)
				tbits_r <= tbits_r + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			cts_prev_r <= cts_s[1];
			tx_empty_irq <= 1'b0;
			rx_threshold_irq <= 1'b0;
			line_error_irq <= 1'b0;
			rx_timeout_irq <= 1'b0;
			modem_change_irq <= 1'b0;
			buffer_error_irq <= 1'b0;
			lin_break_irq <= 1'b0;
			tx_busy <= 1'b0;
			rx_busy <= 1'b0;
		end else begin
			cts_prev_r <= cts_s[1];
			tx_empty_irq <= tfc_r == '0;
			rx_threshold_irq <= (rx_count >= rx_trigger_level) && rx_count != '0;
			line_error_irq <= rx_done & (rx_full | stop_bad | rpe_r);
			rx_timeout_irq <= tbits_r == TOUT_BITS;
			modem_change_irq <= cts_s[1] != cts_prev_r;
			buffer_error_irq <= rx_done & rx_full;
			lin_break_irq <= rx_done & brk_now & lin_mode_enable;
			tx_busy <= tx_st != T_IDLE;
			rx_busy <= rx_st != R_IDLE;
		end
	end
	assign tx_count = tfc_r;
	assign lin_tx_active = lin_go_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_RTS_TRIG: assert property (
		(auto_rts_en && rx_count >= flow_trigger_level)[*2] |-> rts_n)
		else $error("rts not deasserted at trigger level");
	AST_RTS_BACK: assert property (
		(!auto_rts_en || rx_count < flow_trigger_level)[*2] |-> !rts_n)
		else $error("rts not reasserted below trigger");
	AST_CTS_HOLD: assert property (
		tx_st == T_IDLE && auto_cts_en && cts_s[1] |=> tx_st != T_START)
		else $error("transmit started without cts");
	AST_FIFO_CAP: assert property (
		rx_count <= FIFO_FULL && tfc_r <= FIFO_FULL && ob_cnt_r <= 2'h2)
		else $error("fifo count beyond depth");
	AST_HALF_DUP: assert property (
		infrared_enable && $past(infrared_enable) |-> !(tx_busy && rx_busy))
		else $error("infrared transmit and receive together");
	AST_LIN_CLR: assert property (
		$past(tx_st) == T_BRK && tx_st == T_STOP && !$past(lin_tx_start)
		|-> !lin_tx_active)
		else $error("lin start bit not cleared after break");
	AST_BRK_LOW: assert property (
		tx_st == T_BRK && !infrared_enable |=> !ser_tx)
		else $error("break field not driven low");
	AST_RX_GATE: assert property (
		auto_rts_en && rts_n && rx_st == R_IDLE |=> rx_st == R_IDLE)
		else $error("reception started with rts deasserted");
	AST_OVERRUN: assert property (
		rx_done && rx_full |=> buffer_error_irq && line_error_irq ##1 !buffer_error_irq)
		else $error("overrun not reported");
	COV_TX_FRAME: cover property (tx_st == T_STOP ##1 tx_st == T_IDLE);
	COV_LIN_BRK: cover property (tx_st == T_BRK ##[1:1000] tx_st == T_STOP);
	COV_RX_FULL: cover property (rx_full && rx_done);
	COV_IR_PULSE: cover property ($rose(ir_tx));
endmodule : uilc_top
`default_nettype wire

/* File: bench/uilc_far_end.sv */
// far-end serial device model: drives the receive line, captures the transmit line
`timescale 1ns/10ps
`default_nettype none
module uilc_far_end (
	input wire logic clk,
	input wire logic ser_tx,
	input wire logic rts_n,
	input wire logic pause,
	output logic ser_rx,
	output logic cts_n
);
	// ----------------------------------------
	// line drivers and capture
	// ----------------------------------------
	int bit_len = 10;
	logic [7:0] got = 8'h00;
	logic [15:0] lost = 16'h0000;
	initial begin
		ser_rx = 1'h1;
	end
	// low means clear to send
	assign cts_n = pause;
	// one character, lsb first; honour low lets a scenario break flow control
	task automatic send(input logic [7:0] b, input logic stop, input logic honour);
		int k;
		k = 0;
		while (honour && rts_n !== 1'h0 && k < 20000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 20000) lost++;
		ser_rx = 1'h0;
		repeat (bit_len) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			ser_rx = b[i];
			repeat (bit_len) @(negedge clk);
		end
		ser_rx = stop;
		repeat (bit_len) @(negedge clk);
		ser_rx = 1'h1;
		repeat (bit_len) @(negedge clk);
	endtask : send
	// samples mid-bit at falling edges, clear of the register updates
	task automatic catch_byte(output bit ok);
		int k;
		k = 0;
		ok = 1'b0;
		while (ser_tx !== 1'h0 && k < 20000) begin
			@(negedge clk);
			k++;
		end
		if (k < 20000) begin
			ok = 1'b1;
			repeat (bit_len / 2) @(negedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_len) @(negedge clk);
				got[i] = ser_tx;
			end
		end
	endtask : catch_byte
endmodule : uilc_far_end
`default_nettype wire

/* File: bench/test_uilc_top.sv */
// self-checking bench for the uart / infrared / lin controller
`timescale 1ns/10ps
`default_nettype none
module test_uilc_top;
	// ----------------------------------------
	// stimulus signals and instances
	// ----------------------------------------
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'h0;
	logic rx_ready = 1'h0;
	logic baud_mode_hi = 1'h1;
	logic baud_mode_lo = 1'h1;
	logic [15:0] baud_divider = 16'h0008;
	logic [3:0] extra_divider = 4'h0;
	logic parity_enable = 1'h0;
	logic parity_even = 1'h1;
	logic auto_rts_en = 1'h0;
	logic auto_cts_en = 1'h0;
	logic [3:0] flow_trigger_level = 4'h2;
	logic [3:0] rx_trigger_level = 4'h2;
	logic infrared_enable = 1'h0;
	logic rx_invert = 1'h0;
	logic lin_mode_enable = 1'h0;
	logic [3:0] break_length = 4'h1;
	logic lin_tx_start = 1'h0;
	logic ir_rx = 1'h1;
	logic pause = 1'h0;
	logic tx_ready, rx_valid, ser_rx, ser_tx, cts_n, rts_n, ir_tx, tx_busy, lin_tx_active;
	logic tx_empty_irq, rx_threshold_irq;
	logic line_error_irq, rx_timeout_irq, modem_change_irq, buffer_error_irq, lin_break_irq, rx_busy;
	logic [15:0] le_cnt = 16'h0000;
	logic [15:0] be_cnt = 16'h0000;
	logic [15:0] mc_cnt = 16'h0000;
	logic [15:0] lb_cnt = 16'h0000;
	logic rb_seen = 1'h0;
	logic [9:0] ir_frame = {1'h1, 8'hB4, 1'h0};
	logic [7:0] rx_data;
	logic [2:0] rx_err;
	logic [3:0] tx_count, rx_count;
	int error_cnt = 0;
	int checks_done = 0;
	int n;
	bit ok;
	logic [1:0] mode_tab [3] = '{2'h0, 2'h2, 2'h3};
	logic [15:0] div_tab [3] = '{16'h0000, 16'h0001, 16'h0005};
	logic [3:0] ediv_tab [3] = '{4'h0, 4'h9, 4'h0};
	logic [15:0] len_tab [3] = '{16'h0020, 16'h001E, 16'h0007};
	logic [7:0] rx_tab [3] = '{8'h3C, 8'h81, 8'h01};
	logic [2:0] err_tab [3] = '{3'h0, 3'h2, 3'h1};
	always #5 clk = ~clk;
	uilc_top u_dut (.clk, .reset, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_err, .rx_valid,
		.rx_ready, .baud_mode_hi, .baud_mode_lo, .baud_divider, .extra_divider, .parity_enable,
		.parity_even, .auto_rts_en, .auto_cts_en, .flow_trigger_level, .rx_trigger_level,
		.infrared_enable, .rx_invert, .lin_mode_enable, .break_length, .lin_tx_start, .ser_rx,
		.ser_tx, .cts_n, .rts_n, .ir_rx, .ir_tx, .tx_count, .rx_count, .tx_busy, .rx_busy,
		.lin_tx_active, .tx_empty_irq, .rx_threshold_irq, .line_error_irq, .rx_timeout_irq,
		.modem_change_irq, .buffer_error_irq, .lin_break_irq);
	uilc_far_end u_far (.clk, .ser_tx, .rts_n, .pause, .ser_rx, .cts_n);
	// one-cycle pulses counted while they stand
	always @(negedge clk) begin
		if (line_error_irq === 1'h1) le_cnt++;
		if (buffer_error_irq === 1'h1) be_cnt++;
		if (modem_change_irq === 1'h1) mc_cnt++;
		if (lin_break_irq === 1'h1) lb_cnt++;
		if (rx_busy === 1'h1) rb_seen = 1'h1;
	end
	// ----------------------------------------
	// access and check tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task automatic guard(input int k);
		if (k >= 20000) begin
			error_cnt++;
			$display("Error at %0t: wait ran out", $time);
			final_report();
		end
	endtask : guard
	task automatic step(inout int k);
		@(negedge clk);
		k++;
	endtask : step
	function automatic logic sig(input bit ir);
		return ir ? ir_tx : ~ser_tx;
	endfunction : sig
	// one idle cycle between bytes keeps each strobe edge in its own time step
	task automatic put(input logic [7:0] b);
		int k;
		k = 0;
		@(negedge clk);
		tx_data = b;
		tx_valid = 1'h1;
		while (tx_ready !== 1'h1 && k < 20000) step(k);
		guard(k);
		@(negedge clk);
		tx_valid = 1'h0;
	endtask : put
	task automatic get(input logic [7:0] b, input logic [2:0] e);
		int k;
		k = 0;
		@(negedge clk);
		while (rx_valid !== 1'h1 && k < 20000) step(k);
		guard(k);
		chk(rx_data, b);
		chk(rx_err, e);
		rx_ready = 1'h1;
		@(negedge clk);
		rx_ready = 1'h0;
	endtask : get
	// length of the first active run: ser_tx low, or ir_tx high
	task automatic width(input bit ir, output int w);
		int k;
		k = 0;
		w = 0;
		while (sig(ir) !== 1'h1 && k < 20000) step(k);
		guard(k);
		while (sig(ir) === 1'h1 && w < 20000) step(w);
	endtask : width
	task automatic tx_drain;
		int k;
		k = 0;
		while ((tx_busy !== 1'h0 || tx_count !== 4'h0) && k < 20000) step(k);
		guard(k);
	endtask : tx_drain
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge clk);
		reset = 1'h0;
		repeat (2) @(negedge clk);
		chk(tx_ready, 1'h1);
		chk(ser_tx, 1'h1);
		chk(rts_n, 1'h0);
		chk(tx_empty_irq, 1'h1);
		chk(rx_count, 4'h0);
		done("reset");
		for (int i = 0; i < 3; i++) begin
			{baud_mode_hi, baud_mode_lo} = mode_tab[i];
			baud_divider = div_tab[i];
			extra_divider = ediv_tab[i];
			put(8'h01);
			width(1'b0, n);
			chk(n[15:0], len_tab[i]);
			tx_drain();
		end
		baud_divider = 16'h0008;
		done("baud");
		fork
			put(8'hA5);
			u_far.catch_byte(ok);
		join
		chk({ok, u_far.got}, {1'b1, 8'hA5});
		for (int i = 0; i < 3; i++) begin
			parity_enable = (i == 2);
			fork
				u_far.send(rx_tab[i], i == 0, 1'h1);
				get(rx_tab[i], err_tab[i]);
			join
		end
		parity_enable = 1'h0;
		done("data");
		auto_rts_en = 1'h1;
		for (int i = 0; i < 4; i++) u_far.send(8'(i + 16), 1'h1, 1'h1);
		chk(rx_count, 4'h2);
		chk(rts_n, 1'h1);
		chk(rx_threshold_irq, 1'h1);
		chk(rx_timeout_irq, 1'h0);
		// far end ignores the deasserted request on purpose
		u_far.send(8'hFF, 1'h1, 1'h0);
		chk(rx_count, 4'h2);
		repeat (320) @(negedge clk);
		chk(rx_timeout_irq, 1'h1);
		get(8'h10, 3'h0);
		repeat (3) @(negedge clk);
		chk(rts_n, 1'h0);
		for (int i = 1; i < 4; i++) get(8'(i + 16), 3'h0);
		auto_rts_en = 1'h0;
		done("rts");
		// two in the output buffer, eight in the fifo, the eleventh dropped
		for (int i = 0; i < 11; i++) u_far.send(8'(i + 64), 1'h1, 1'h1);
		chk(rx_count, 4'h8);
		chk(be_cnt, 16'h0001);
		for (int i = 0; i < 10; i++) get(8'(i + 64), 3'h0);
		done("overrun");
		auto_cts_en = 1'h1;
		pause = 1'h1;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 8; i++) put(8'(i + 128));
		@(negedge clk);
		chk(tx_count, 4'h8);
		chk(tx_ready, 1'h0);
		chk(ser_tx, 1'h1);
		pause = 1'h0;
		for (int i = 0; i < 8; i++) begin
			u_far.catch_byte(ok);
			chk({ok, u_far.got}, {1'b1, 8'(i + 128)});
		end
		tx_drain();
		chk(mc_cnt, 16'h0002);
		done("cts");
		lin_mode_enable = 1'h1;
		lin_tx_start = 1'h1;
		@(negedge clk);
		lin_tx_start = 1'h0;
		chk(lin_tx_active, 1'h1);
		width(1'b0, n);
		chk(n[15:0], 16'h001E);
		@(negedge clk);
		chk(lin_tx_active, 1'h0);
		fork
			u_far.send(8'h00, 1'h0, 1'h1);
			get(8'h00, 3'h6);
		join
		chk(lb_cnt, 16'h0001);
		repeat (20) @(negedge clk);
		lin_mode_enable = 1'h0;
		done("lin");
		{baud_mode_hi, baud_mode_lo} = 2'h0;
		baud_divider = 16'h0000;
		infrared_enable = 1'h1;
		// reception ahead of transmission, so no turnaround wait is owed
		for (int i = 0; i < 10; i++) begin
			ir_rx = ir_frame[i];
			repeat (6) @(negedge clk);
			ir_rx = 1'h1;
			repeat (26) @(negedge clk);
		end
		get(8'hB4, 3'h0);
		put(8'hFF);
		width(1'b1, n);
		chk(n[15:0], 16'h0006);
		chk(ser_tx, 1'h1);
		tx_drain();
		done("infrared");
		chk(le_cnt, 16'h0004);
		chk(rb_seen, 1'h1);
		chk(u_far.lost, 16'h0000);
		final_report();
	end
endmodule : test_uilc_top
`default_nettype wire
